// ### bto_bridge.sv
`timescale 1ns/1ps
module bto_bridge (
  input  wire logic              clk_in,       // Core clock.
  input  wire logic              nrst_in,      // Synchronous reset, low.
  input  wire logic              enable_in,    // Bridge drive enabled.
  input  wire logic              hs_cmd_in,    // 1 high side, 0 low side.
  input  wire logic              gate_ok_in,   // Handshake: gates off.
  input  wire logic              oc_in,        // Synced comparator.
  input  wire logic              fault_in,     // Latched fault.
  input  wire bto_pkg::bto_cnt_t dead_cyc_in,  // Added dead-time cycles.
  input  wire bto_pkg::bto_cnt_t dg_cyc_in,    // Deglitch cycles.
  output logic                   gate_hs_out,  // High-side gate on.
  output logic                   gate_ls_out,  // Low-side gate on.
  output logic                   oc_evt_out    // Overcurrent event pulse.
);
  import bto_pkg::*;

  bto_state_e st_q;
  logic       side_q;
  bto_cnt_t   dt_cnt_q;
  bto_cnt_t   dg_cnt_q;
  logic       dg_done_q;
  logic       evt_d;
  logic       trip;

  // ==========================================================
  // Overcurrent deglitch
  // A drop of the comparator restarts the count, so a train of short
  // glitches never adds up to a fault.
  assign evt_d = oc_in && !dg_done_q && (dg_cnt_q == dg_cyc_in - 11'd1);

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      dg_cnt_q  <= '0;
      dg_done_q <= 1'b0;
      oc_evt_out <= 1'b0;
    end
    else
    begin
      oc_evt_out <= evt_d;
      if (!oc_in)
      begin
        dg_cnt_q  <= '0;
        dg_done_q <= 1'b0;
      end
      else if (evt_d)
        dg_done_q <= 1'b1;
      else if (!dg_done_q)
        dg_cnt_q <= dg_cnt_q + 11'd1;
    end
  end

  // ==========================================================
  // Gate sequencing
  assign trip = fault_in || evt_d || !enable_in;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      st_q        <= BTO_ST_OFF;
      side_q      <= 1'b0;
      dt_cnt_q    <= '0;
      gate_hs_out <= 1'b0;
      gate_ls_out <= 1'b0;
    end
    else if (trip)
    begin
      st_q        <= BTO_ST_OFF;
      gate_hs_out <= 1'b0;
      gate_ls_out <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        BTO_ST_OFF:
        begin
          st_q     <= BTO_ST_DEAD;
          side_q   <= hs_cmd_in;
          dt_cnt_q <= '0;
        end
        BTO_ST_DEAD:
        begin
          // The added delay only starts once the handshake confirms off.
          if (!gate_ok_in)
            dt_cnt_q <= '0;
          else if (dt_cnt_q >= dead_cyc_in)
          begin
            st_q        <= BTO_ST_ON;
            gate_hs_out <= side_q;
            gate_ls_out <= !side_q;
          end
          else
            dt_cnt_q <= dt_cnt_q + 11'd1;
        end
        BTO_ST_ON:
        begin
          if (hs_cmd_in != side_q)
          begin
            st_q        <= BTO_ST_DEAD;
            side_q      <= hs_cmd_in;
            dt_cnt_q    <= '0;
            gate_hs_out <= 1'b0;
            gate_ls_out <= 1'b0;
          end
        end
        default:
        begin
          st_q        <= BTO_ST_OFF;
          gate_hs_out <= 1'b0;
          gate_ls_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : bto_bridge

// ### bto_gate_model.sv
`timescale 1ns/1ps
module bto_gate_model #(
  parameter int DLY = 3                 // Cycles for gate charge to decay.
) (
  input  wire logic       mclk_in,      // Core clock.
  input  wire logic [3:0] gate_hs_in,   // High-side gate enables.
  input  wire logic [3:0] gate_ls_in,   // Low-side gate enables.
  input  wire logic [3:0] short_in,     // Commanded load short per bridge.
  output logic      [3:0] gate_off_ok_out, // Both gates confirmed off.
  output logic      [3:0] oc_cmp_out    // Comparator over threshold.
);
  int unsigned cnt_q [4];
  // ==========================================================
  // Gate charge decays slowly, so off is confirmed only a few cycles after release.
  always_ff @(posedge mclk_in)
  begin
    for (int i = 0; i < 4; i++)
    begin
      cnt_q[i] <= (gate_hs_in[i] | gate_ls_in[i]) ? 0 : ((cnt_q[i] < DLY) ? cnt_q[i] + 1 : DLY);
    end
  end
  // Each bridge confirms off from its own decay count, not from bridge 1's.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      gate_off_ok_out[i] = (cnt_q[i] >= DLY) && !(gate_hs_in[i] | gate_ls_in[i]);
    end
  end
  assign oc_cmp_out      = short_in;
endmodule : bto_gate_model

// ### bto_map.svh
`ifndef BTO_MAP_SVH
`define BTO_MAP_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define BTO_IDX_DEAD_TIME   6'h1B
`define BTO_IDX_DEGLITCH    6'h1C
`define BTO_IDX_PULLDOWN    6'h1D
`define BTO_IDX_THRESH_A    6'h1F
`define BTO_IDX_THRESH_B    6'h20
`define BTO_IDX_IRQ_STATUS  6'h28
`define BTO_IDX_IRQ_CLEAR   6'h29
`define BTO_IDX_IRQ_ENABLE  6'h2A
`define BTO_IDX_DRIVE_EN    6'h2B
// ==========================================================
// Reset values
`define BTO_RST_DEAD_TIME   8'h00
`define BTO_RST_DEGLITCH    8'hAA
`define BTO_RST_PULLDOWN    8'h00
`define BTO_RST_THRESH      8'hDD
`define BTO_RST_NIBBLE4     4'h0
// ==========================================================
// Field layout: bridge 1 in the top bits
`define BTO_F2_TOP_LSB      3
`define BTO_F4_TOP_LSB      1
`define BTO_CODE_NORMAL     2'h0
// ==========================================================
// Timing in ns and the clock period
`define BTO_CLK_NS          8
`define BTO_DT_00_NS        0
`define BTO_DT_01_NS        2000
`define BTO_DT_10_NS        4000
`define BTO_DT_11_NS        8000
`define BTO_DG_00_NS        1000
`define BTO_DG_01_NS        2000
`define BTO_DG_10_NS        4000
`define BTO_DG_11_NS        8000
`endif

// ### bto_pkg.sv
package bto_pkg;
  typedef logic [10:0] bto_cnt_t;
  typedef logic [1:0]  bto_code_t;
  typedef enum logic [1:0] {
    BTO_ST_OFF  = 2'b00,
    BTO_ST_DEAD = 2'b01,
    BTO_ST_ON   = 2'b11
  } bto_state_e;
endpackage : bto_pkg

// ### bto_top.sv
// Operation
// - Dead-time register 1Bh, four 2-bit fields, reset 0.
// - Dead-time codes add 0, 2, 4, 8 us.
// - Deglitch register 1Ch, reset AAh.
// - Deglitch codes give 1, 2, 4, 8 us.
// - Pulldown register 1Dh, four fields, reset 0.
// - After fault apply selected pulldown current code.
// - Threshold register 1Fh, bridges 1-2, reset DDh.
// - Threshold register 20h, bridges 3-4, reset DDh.
// - Threshold codes select sixteen ascending comparator levels.
// - Each bridge's fault uses only its own field.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "bto_map.svh"
module bto_top #(
  parameter int NBR = 4                         // Number of bridges.
) (
  input  wire logic             mclk_in,                // Core clock, 125 MHz.
  input  wire logic             nrst_in,                // Synchronous reset, low.
  input  wire logic [7:0]       avs_address_in,         // Byte address.
  input  wire logic             avs_read_in,            // Read request.
  input  wire logic             avs_write_in,           // Write request.
  input  wire logic [3:0]       avs_byteenable_in,      // Byte lanes.
  input  wire logic [31:0]      avs_writedata_in,       // Write data.
  output logic [31:0]           avs_readdata_out,       // Read data.
  output logic                  avs_waitrequest_out,    // Wait request.
  input  wire logic [NBR-1:0]   hs_cmd_in,              // Side command per bridge.
  input  wire logic [NBR-1:0]   gate_off_ok_in,         // Async handshake, gates off.
  input  wire logic [NBR-1:0]   oc_cmp_in,              // Async overcurrent comparators.
  output logic [NBR-1:0]        gate_hs_out,            // High-side gate enables.
  output logic [NBR-1:0]        gate_ls_out,            // Low-side gate enables.
  output logic [2*NBR-1:0]      gate_pulldown_sel_out,  // Pulldown code, bridge 1 top.
  output logic [15:0]           oc_threshold_out,       // Threshold codes, bridge 1 top.
  output logic                  irq_out                 // Level interrupt.
);
  import bto_pkg::*;

  // ==========================================================
  // Decoding helpers
  function automatic bto_cnt_t ns2cyc(input int ns);
    ns2cyc = bto_cnt_t'((ns + `BTO_CLK_NS - 1) / `BTO_CLK_NS);
  endfunction : ns2cyc

  function automatic bto_code_t fld2(input logic [7:0] r, input int i);
    fld2 = r[(`BTO_F2_TOP_LSB - i) * 2 +: 2];
  endfunction : fld2

  function automatic bto_cnt_t dead_cyc(input bto_code_t c);
    unique case (c)
      2'h0: dead_cyc = ns2cyc(`BTO_DT_00_NS);
      2'h1: dead_cyc = ns2cyc(`BTO_DT_01_NS);
      2'h2: dead_cyc = ns2cyc(`BTO_DT_10_NS);
      2'h3: dead_cyc = ns2cyc(`BTO_DT_11_NS);
    endcase
  endfunction : dead_cyc

  function automatic bto_cnt_t dg_cyc(input bto_code_t c);
    unique case (c)
      2'h0: dg_cyc = ns2cyc(`BTO_DG_00_NS);
      2'h1: dg_cyc = ns2cyc(`BTO_DG_01_NS);
      2'h2: dg_cyc = ns2cyc(`BTO_DG_10_NS);
      2'h3: dg_cyc = ns2cyc(`BTO_DG_11_NS);
    endcase
  endfunction : dg_cyc

  // ==========================================================
  // Registers
  logic [7:0]     dead_time_q;
  logic [7:0]     deglitch_q;
  logic [7:0]     pulldown_q;
  logic [7:0]     thresh_a_q;
  logic [7:0]     thresh_b_q;
  logic [NBR-1:0] sts_q;
  logic [NBR-1:0] sts_d;
  logic [NBR-1:0] ien_q;
  logic [NBR-1:0] den_q;
  logic           wait_q;
  logic [31:0]    rdata_q;
  logic [5:0]     idx;
  logic           req;
  logic           wr;
  logic [NBR-1:0] clr;
  logic [NBR-1:0] evt;
  logic [NBR-1:0] oc_s1_q;
  logic [NBR-1:0] oc_s2_q;
  logic [NBR-1:0] ok_s1_q;
  logic [NBR-1:0] ok_s2_q;
  logic [2*NBR-1:0] pd_sel_q;
  logic           irq_q;

  assign idx = avs_address_in[7:2];
  assign req = avs_read_in || avs_write_in;
  assign wr  = avs_write_in && !wait_q && avs_byteenable_in[0];
  assign clr = (wr && idx == `BTO_IDX_IRQ_CLEAR) ? avs_writedata_in[NBR-1:0] : '0;

  // ==========================================================
  // Avalon handshake: every access waits exactly one cycle.
  // Registering the read data costs a cycle but keeps the decode out of
  // the bus read path.
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      wait_q <= 1'b1;
    else
      wait_q <= !(wait_q && req);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      rdata_q <= '0;
    else if (avs_read_in && wait_q)
    begin
      rdata_q <= '0;
      unique case (idx)
        `BTO_IDX_DEAD_TIME:  rdata_q[7:0] <= dead_time_q;
        `BTO_IDX_DEGLITCH:   rdata_q[7:0] <= deglitch_q;
        `BTO_IDX_PULLDOWN:   rdata_q[7:0] <= pulldown_q;
        `BTO_IDX_THRESH_A:   rdata_q[7:0] <= thresh_a_q;
        `BTO_IDX_THRESH_B:   rdata_q[7:0] <= thresh_b_q;
        `BTO_IDX_IRQ_STATUS: rdata_q[NBR-1:0] <= sts_q;
        `BTO_IDX_IRQ_ENABLE: rdata_q[NBR-1:0] <= ien_q;
        `BTO_IDX_DRIVE_EN:   rdata_q[NBR-1:0] <= den_q;
        default:             rdata_q <= '0;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      dead_time_q <= `BTO_RST_DEAD_TIME;
      deglitch_q  <= `BTO_RST_DEGLITCH;
      pulldown_q  <= `BTO_RST_PULLDOWN;
      thresh_a_q  <= `BTO_RST_THRESH;
      thresh_b_q  <= `BTO_RST_THRESH;
      ien_q       <= `BTO_RST_NIBBLE4;
      den_q       <= `BTO_RST_NIBBLE4;
    end
    else if (wr)
    begin
      unique case (idx)
        `BTO_IDX_DEAD_TIME:  dead_time_q <= avs_writedata_in[7:0];
        `BTO_IDX_DEGLITCH:   deglitch_q  <= avs_writedata_in[7:0];
        `BTO_IDX_PULLDOWN:   pulldown_q  <= avs_writedata_in[7:0];
        `BTO_IDX_THRESH_A:   thresh_a_q  <= avs_writedata_in[7:0];
        `BTO_IDX_THRESH_B:   thresh_b_q  <= avs_writedata_in[7:0];
        `BTO_IDX_IRQ_ENABLE: ien_q       <= avs_writedata_in[NBR-1:0];
        `BTO_IDX_DRIVE_EN:   den_q       <= avs_writedata_in[NBR-1:0];
        default:             ien_q       <= ien_q;
      endcase
    end
  end

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      oc_s1_q <= '0;
      oc_s2_q <= '0;
      ok_s1_q <= '0;
      ok_s2_q <= '0;
    end
    else
    begin
      oc_s1_q <= oc_cmp_in;
      oc_s2_q <= oc_s1_q;
      ok_s1_q <= gate_off_ok_in;
      ok_s2_q <= ok_s1_q;
    end
  end

  // ==========================================================
  // Fault status and interrupt
  // A new event in the same cycle as its clear keeps the bit set.
  assign sts_d = (sts_q & ~clr) | evt;

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      sts_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & ien_q);
    end
  end

  // ==========================================================
  // Per-bridge logic
  genvar g;
  generate
    for (g = 0; g < NBR; g++)
    begin : g_br
      bto_bridge u_br (
        .clk_in      (mclk_in),
        .nrst_in     (nrst_in),
        .enable_in   (den_q[g]),
        .hs_cmd_in   (hs_cmd_in[g]),
        .gate_ok_in  (ok_s2_q[g]),
        .oc_in       (oc_s2_q[g]),
        .fault_in    (sts_q[g]),
        .dead_cyc_in (dead_cyc(fld2(dead_time_q, g))),
        .dg_cyc_in   (dg_cyc(fld2(deglitch_q, g))),
        .gate_hs_out (gate_hs_out[g]),
        .gate_ls_out (gate_ls_out[g]),
        .oc_evt_out  (evt[g])
      );

      // While faulted the bridge's own code is driven; otherwise the
      // normal pulldown code, so the gate stage uses its usual current.
      always_ff @(posedge mclk_in)
      begin
        if (!nrst_in)
          pd_sel_q[(`BTO_F2_TOP_LSB - g) * 2 +: 2] <= `BTO_CODE_NORMAL;
        else if (sts_d[g])
          pd_sel_q[(`BTO_F2_TOP_LSB - g) * 2 +: 2] <= fld2(pulldown_q, g);
        else
          pd_sel_q[(`BTO_F2_TOP_LSB - g) * 2 +: 2] <= `BTO_CODE_NORMAL;
      end
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign avs_readdata_out      = rdata_q;
  assign avs_waitrequest_out   = wait_q;
  assign gate_pulldown_sel_out = pd_sel_q;
  assign oc_threshold_out      = {thresh_a_q, thresh_b_q};
  assign irq_out               = irq_q;
endmodule : bto_top

// ### bto_top_properties.sv
`timescale 1ns/1ps
module bto_top_properties #(
  parameter int NBR = 4                               // Number of bridges.
) (
  input wire logic             mclk_in,               // Core clock.
  input wire logic             nrst_in,               // Synchronous reset, low.
  input wire logic [7:0]       avs_address_in,        // Byte address.
  input wire logic             avs_read_in,           // Read request.
  input wire logic             avs_write_in,          // Write request.
  input wire logic [3:0]       avs_byteenable_in,     // Byte lanes.
  input wire logic [31:0]      avs_writedata_in,      // Write data.
  input wire logic [31:0]      avs_readdata_out,      // Read data.
  input wire logic             avs_waitrequest_out,   // Wait request.
  input wire logic [NBR-1:0]   hs_cmd_in,             // Side command.
  input wire logic [NBR-1:0]   gate_off_ok_in,        // Gates-off handshake.
  input wire logic [NBR-1:0]   oc_cmp_in,             // Comparators.
  input wire logic [NBR-1:0]   gate_hs_out,           // High-side gates.
  input wire logic [NBR-1:0]   gate_ls_out,           // Low-side gates.
  input wire logic [2*NBR-1:0] gate_pulldown_sel_out, // Pulldown codes.
  input wire logic [15:0]      oc_threshold_out,      // Threshold codes.
  input wire logic             irq_out                // Interrupt.
);
  logic [10:0] hi_q;
  // ==========================================================
  // Consecutive high cycles of the bridge 1 comparator, saturating.
  always_ff @(posedge mclk_in)
  begin
    hi_q <= !oc_cmp_in[0] ? 11'h000 : (hi_q == 11'h7FF ? hi_q : hi_q + 11'h001);
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  a_thresh_reset: assert property ($rose(nrst_in) |-> oc_threshold_out == 16'hDDDD)
    else $error("threshold codes not at reset value");
  a_outputs_reset: assert property ($rose(nrst_in) |-> gate_pulldown_sel_out == '0 && !irq_out)
    else $error("pulldown or interrupt not cleared by reset");
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer not after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_thresh_hold: assert property (!(avs_write_in && !avs_waitrequest_out) |=> $stable(oc_threshold_out))
    else $error("threshold changed without a write");
  a_gate_excl: assert property ((gate_hs_out & gate_ls_out) == '0)
    else $error("both gates of a bridge on");
  a_dead_gap: assert property (((gate_ls_out & $past(gate_hs_out)) | (gate_hs_out & $past(gate_ls_out))) == '0)
    else $error("opposite gate on without an off cycle");
  a_deglitch_min: assert property ($rose(gate_pulldown_sel_out[7:6] != 2'h0) |-> hi_q >= 11'h07D)
    else $error("fault reported before the deglitch time");
  a_fault_off: assert property ($past(gate_pulldown_sel_out[7:6]) != 2'h0 && gate_pulldown_sel_out[7:6] != 2'h0 |-> !gate_hs_out[0] && !gate_ls_out[0])
    else $error("bridge 1 gate on during fault");
endmodule : bto_top_properties
bind bto_top bto_top_properties #(.NBR(NBR)) u_props (.mclk_in, .nrst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
  .avs_waitrequest_out, .hs_cmd_in, .gate_off_ok_in, .oc_cmp_in, .gate_hs_out, .gate_ls_out,
  .gate_pulldown_sel_out, .oc_threshold_out, .irq_out);

// ### tb_bridge_timing_ocp_config.sv
`timescale 1ns/1ps
module tb_bridge_timing_ocp_config;
  logic        mclk_in = 1'b0, nrst_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [7:0]  avs_address_in = 8'h00;
  logic [3:0]  avs_byteenable_in = 4'h0, hs_cmd_in = 4'h0, short_q = 4'h0;
  logic [31:0] avs_writedata_in = 32'h00000000, avs_readdata_out, q;
  logic        avs_waitrequest_out, irq_out;
  logic [3:0]  gate_off_ok_in, oc_cmp_in, gate_hs_out, gate_ls_out;
  logic [7:0]  gate_pulldown_sel_out;
  logic [15:0] oc_threshold_out;
  int          err_total = 0, checked = 0, n;
  bto_top DUT (.mclk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .hs_cmd_in,
    .gate_off_ok_in, .oc_cmp_in, .gate_hs_out, .gate_ls_out, .gate_pulldown_sel_out,
    .oc_threshold_out, .irq_out);
  bto_gate_model u_gate (.mclk_in, .gate_hs_in(gate_hs_out), .gate_ls_in(gate_ls_out),
    .short_in(short_q), .gate_off_ok_out(gate_off_ok_in), .oc_cmp_out(oc_cmp_in));
  initial
  begin
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi)
    begin
      $display("BAD %0t got %h exp %h..%h", $time, got, lo, hi);
      err_total++;
    end
  endtask : chk_rng
  // ==========================================================
  // Bus cycle: the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     input logic [3:0] b);
    @(posedge mclk_in);
    avs_address_in <= {idx, 2'h0};
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= {24'h000000, d};
    avs_byteenable_in <= b;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hF);
    chk(q, {24'h000000, exp});
  endtask : rd_chk
  task automatic t_regs;
    logic [5:0] idx [5] = '{6'h1B, 6'h1C, 6'h1D, 6'h1F, 6'h20};
    logic [7:0] rst [5] = '{8'h00, 8'hAA, 8'h00, 8'hDD, 8'hDD};
    chk(oc_threshold_out, 16'hDDDD);
    for (int i = 0; i < 5; i++)
    begin
      rd_chk(idx[i], rst[i]);
      bus(1'b1, idx[i], 8'h5A ^ i[7:0], 4'h1);
      bus(1'b1, idx[i], 8'hFF, 4'h0);
      rd_chk(idx[i], 8'h5A ^ i[7:0]);
    end
    chk(oc_threshold_out, 16'h595E);
    rd_chk(6'h3F, 8'h00);
  endtask : t_regs
  task automatic t_dead;
    int exp_n [4] = '{0, 250, 500, 1000};
    bus(1'b1, 6'h2B, 8'h01, 4'h1);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 6'h1B, {c[1:0], 6'h00}, 4'h1);
      repeat (1100) @(posedge mclk_in);
      chk(gate_hs_out[0] | gate_ls_out[0], 1'b1);
      hs_cmd_in <= hs_cmd_in ^ 4'h1;
      do @(posedge mclk_in); while ((gate_hs_out[0] | gate_ls_out[0]) !== 1'b0);
      n = 0;
      while ((hs_cmd_in[0] ? gate_hs_out[0] : gate_ls_out[0]) !== 1'b1)
      begin
        @(posedge mclk_in);
        n++;
      end
      chk_rng(n, exp_n[c] + 1, exp_n[c] + 12);
    end
  endtask : t_dead
  task automatic t_oc;
    int dg [4] = '{125, 250, 500, 1000};
    bus(1'b1, 6'h1D, 8'hD0, 4'h1);
    bus(1'b1, 6'h2A, 8'h01, 4'h1);
    for (int c = 3; c >= 0; c--)
    begin
      bus(1'b1, 6'h1C, {c[1:0], 6'h2A}, 4'h1);
      repeat (20) @(posedge mclk_in);
      short_q <= 4'h1;
      n = 0;
      while (irq_out !== 1'b1)
      begin
        @(posedge mclk_in);
        n++;
      end
      chk_rng(n, dg[c], dg[c] + 8);
      repeat (3) @(posedge mclk_in);
      chk(gate_pulldown_sel_out, 8'hC0);
      chk({gate_hs_out[0], gate_ls_out[0]}, 2'h0);
      short_q <= 4'h0;
      bus(1'b1, 6'h29, 8'h01, 4'h1);
      repeat (3) @(posedge mclk_in);
      chk({irq_out, gate_pulldown_sel_out}, 9'h000);
    end
  endtask : t_oc
  // ==========================================================
  // Two short pulses whose sum exceeds the deglitch time must not count together.
  task automatic t_glitch;
    repeat (2)
    begin
      short_q <= 4'h1;
      repeat (100) @(posedge mclk_in);
      short_q <= 4'h0;
      repeat (5) @(posedge mclk_in);
    end
    repeat (20) @(posedge mclk_in);
    chk(irq_out, 1'b0);
    bus(1'b1, 6'h2A, 8'h00, 4'h1);
    short_q <= 4'h1;
    repeat (200) @(posedge mclk_in);
    chk(irq_out, 1'b0);
    rd_chk(6'h28, 8'h01);
    bus(1'b1, 6'h2A, 8'h01, 4'h1);
    repeat (3) @(posedge mclk_in);
    chk(irq_out, 1'b1);
    short_q <= 4'h0;
    bus(1'b1, 6'h29, 8'h01, 4'h1);
    rd_chk(6'h28, 8'h00);
  endtask : t_glitch
  task automatic test_done;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_dead();
    t_oc();
    t_glitch();
    test_done();
  end
  initial
  begin
    #400000;
    err_total++;
    test_done();
  end
endmodule : tb_bridge_timing_ocp_config
